// *** hdl/lcd_driver_control_regs.sv ***
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// LCD driver control register bank on APB
module lcd_driver_control_regs #(
    parameter bit large_variant = 1'b1 // Fourth segment register present
) (
    input wire logic pclk, // Clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire lcd_ctrl_pkg::power_mode_t power_mode, // Chip power mode
    output lcd_ctrl_pkg::lcd_cfg_t cfg, // Registered drive settings
    output logic [47:0] seg_func_bit, // Per-pin segment function enable
    output logic drive_active // Common/segment drive running
);
    import lcd_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0] pump_ctrl;
        logic [7:0] main_ctrl;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [7:0] sel_c;
        logic [7:0] sel_d;
        lcd_cfg_t cfg;
        logic [47:0] seg;
        logic active;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic wr_stb;
    logic hit;
    logic [7:0] rd_sel;
    logic [31:0] rd_word;
    logic rd_ready;
    logic rd_err;
    lcd_cfg_t cfg_now;

    // Masked byte-0 update, only implemented bits stored
    function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask, input logic en);
        upd = en ? (wd & mask) : old;
    endfunction

    // Address decode and read selection
    always_comb begin
        hit = 1'b1;
        rd_sel = 8'h00;
        if (paddr == addr_pump_ctrl) begin
            rd_sel = state_q.pump_ctrl & pump_ctrl_mask;
        end else if (paddr == addr_main_ctrl) begin
            rd_sel = state_q.main_ctrl & main_ctrl_mask;
        end else if (paddr == addr_seg_sel_a) begin
            rd_sel = state_q.sel_a;
        end else if (paddr == addr_seg_sel_b) begin
            rd_sel = state_q.sel_b;
        end else if (paddr == addr_seg_sel_c) begin
            rd_sel = state_q.sel_c & seg_sel_c_mask;
        end else if (paddr == addr_seg_sel_d && large_variant) begin
            rd_sel = state_q.sel_d;
        end else if (paddr == addr_status) begin
            rd_sel = {7'h00, state_q.active};
        end else begin
            hit = 1'b0;
        end
    end

    lcd_apb_if u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .rdata_in(rd_sel),
        .hit_in(hit),
        .wr_stb(wr_stb),
        .prdata(rd_word),
        .pready(rd_ready),
        .pslverr(rd_err)
    );

    lcd_cfg_gate u_gate (
        .pump_ctrl(state_d.pump_ctrl),
        .main_ctrl(state_d.main_ctrl),
        .power_mode(power_mode),
        .cfg(cfg_now)
    );

    // Next state; status register is read-only so writes to it are dropped
    always_comb begin
        logic we;
        we = 1'b0;
        state_d = state_q;
        we = wr_stb & pstrb[0];
        state_d.pump_ctrl = upd(state_q.pump_ctrl, pwdata[7:0], pump_ctrl_mask,
                                we && paddr == addr_pump_ctrl);
        state_d.main_ctrl = upd(state_q.main_ctrl, pwdata[7:0], main_ctrl_mask,
                                we && paddr == addr_main_ctrl);
        state_d.sel_a = upd(state_q.sel_a, pwdata[7:0], full_mask, we && paddr == addr_seg_sel_a);
        state_d.sel_b = upd(state_q.sel_b, pwdata[7:0], full_mask, we && paddr == addr_seg_sel_b);
        state_d.sel_c = upd(state_q.sel_c, pwdata[7:0], seg_sel_c_mask, we && paddr == addr_seg_sel_c);
        state_d.sel_d = upd(state_q.sel_d, pwdata[7:0], full_mask,
                            we && large_variant && paddr == addr_seg_sel_d);
        state_d.cfg = cfg_now;
        // Pins 16..37 have no select bit and stay I/O
        state_d.seg = {state_d.sel_d, state_d.sel_c[1:0], 22'h000000,
                       state_d.sel_b, state_d.sel_a};
        // No drive at all while the effective enable is low
        state_d.active = cfg_now.display_on;
        // Read data is captured only at setup, so the output needs no mux behind the flop
        state_d.rdata = (psel & ~penable) ? rd_word : 32'h00000000;
        state_d.ready = psel & ~penable;
        state_d.err = rd_err & ~state_q.ready ? 1'b0 : (psel & ~penable & ~hit);
    end

    // One register stage for all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs from flops; pready and pslverr are ANDed with the registered ready
    always_comb begin
        cfg = state_q.cfg;
        seg_func_bit = state_q.seg;
        drive_active = state_q.active;
        prdata = state_q.rdata;
        pready = state_q.ready & rd_ready;
        pslverr = state_q.ready & state_q.err;
    end
endmodule
`default_nettype wire

// *** hdl/lcd_ctrl_pkg.sv ***
// Notes on behaviour
// - Pump-control bit 3 picks resistor-bias supply: 0 external pin, 1 charge pump.
// - Pump-control bits 1:0 pick pump output: 3.3V, 3.0V, 2.7V, 4.5V.
// - Main-control bit 7 picks drive waveform: 0 type A, 1 type B.
// - Main-control bit 6 picks bias method: 0 resistor, 1 capacitor.
// - Capacitor bias switches on the internal charge pump for bias generation.
// - Main-control bits 5:4 pick capacitor-bias source: pins, reference, 3V, supply.
// - Main-control bits 2:1 pick bias current: 25, 50, 100, 200 uA.
// - Display enable works in Normal, Slow, Idle; Sleep forces display off.
// - First select register bit n picks segment function for pin n, 0..7.
// - Second select register bits 0..7 enable segment function for pins 8..15.
// - Third select register bits 1:0 serve pins 39:38; bits 7:2 read zero.
// - Larger variant only: fourth select register enables pins 40..47.
// - Unused pump-control bits 7:4 and 2 read zero; all bits reset zero.
// - With display disabled, common and segment drive stop, display blanks.
package lcd_ctrl_pkg;

    // Register byte addresses
    localparam logic [11:0] addr_pump_ctrl = 12'h000;
    localparam logic [11:0] addr_main_ctrl = 12'h004;
    localparam logic [11:0] addr_seg_sel_a = 12'h008;
    localparam logic [11:0] addr_seg_sel_b = 12'h00C;
    localparam logic [11:0] addr_seg_sel_c = 12'h010;
    localparam logic [11:0] addr_seg_sel_d = 12'h014;
    localparam logic [11:0] addr_status = 12'h018;

    // Implemented-bit masks
    localparam logic [7:0] pump_ctrl_mask = 8'h0B;
    localparam logic [7:0] main_ctrl_mask = 8'hF7;
    localparam logic [7:0] seg_sel_c_mask = 8'h03;
    localparam logic [7:0] full_mask = 8'hFF;
    localparam logic [7:0] reg_reset = 8'h00;

    // Field positions
    localparam int pos_supply_sel = 3;
    localparam int pos_pump_volt = 0;
    localparam int pos_waveform = 7;
    localparam int pos_bias_method = 6;
    localparam int pos_cap_source = 4;
    localparam int pos_bias_current = 1;
    localparam int pos_display_en = 0;

    // Power modes from the system
    typedef enum logic [1:0] {
        pm_normal = 2'h0,
        pm_slow = 2'h1,
        pm_idle = 2'h2,
        pm_sleep = 2'h3
    } power_mode_t;

    // Settings handed to the analog and timing logic
    typedef struct packed {
        logic drive_supply_sel;
        logic [1:0] pump_voltage_sel;
        logic waveform_b;
        logic bias_method_sel;
        logic [1:0] cap_bias_source_sel;
        logic [1:0] bias_current_sel;
        logic pump_on;
        logic display_on;
    } lcd_cfg_t;

endpackage

// *** hdl/lcd_apb_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// APB slave front end: zero wait states, flags unmapped addresses
module lcd_apb_if (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write
    input wire logic [11:0] paddr, // Byte address
    input wire logic [7:0] rdata_in, // Read data from the bank
    input wire logic hit_in, // Address is mapped
    output logic wr_stb, // One-cycle write strobe
    output logic [31:0] prdata, // Read data
    output logic pready, // Always ready
    output logic pslverr // Unmapped access
);
    import lcd_ctrl_pkg::*;

    // Writes commit at the completing edge of the access phase
    always_comb begin
        wr_stb = psel & penable & pwrite & hit_in;
        pready = 1'b1;
        pslverr = psel & penable & ~hit_in;
        prdata = (psel & ~pwrite) ? {24'h000000, rdata_in} : 32'h00000000;
    end
endmodule
`default_nettype wire

// *** hdl/lcd_cfg_gate.sv ***
`timescale 1ns/10ps
`default_nettype none
// Derives effective drive settings from stored fields and power mode
module lcd_cfg_gate (
    input wire logic [7:0] pump_ctrl, // Stored pump control
    input wire logic [7:0] main_ctrl, // Stored main control
    input wire lcd_ctrl_pkg::power_mode_t power_mode, // Chip power mode
    output lcd_ctrl_pkg::lcd_cfg_t cfg // Effective settings
);
    import lcd_ctrl_pkg::*;

    // Sleep overrides enable so the panel never sees DC in sleep
    always_comb begin
        cfg.drive_supply_sel = pump_ctrl[pos_supply_sel];
        cfg.pump_voltage_sel = pump_ctrl[pos_pump_volt +: 2];
        cfg.waveform_b = main_ctrl[pos_waveform];
        cfg.bias_method_sel = main_ctrl[pos_bias_method];
        cfg.cap_bias_source_sel = main_ctrl[pos_cap_source +: 2];
        cfg.bias_current_sel = main_ctrl[pos_bias_current +: 2];
        // Pump runs for cap bias, or for resistor bias fed from the pump
        cfg.pump_on = main_ctrl[pos_bias_method] | pump_ctrl[pos_supply_sel];
        cfg.display_on = main_ctrl[pos_display_en] & (power_mode != pm_sleep);
    end
endmodule
`default_nettype wire

// *** sim/lcd_regs_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level watcher of the control bank; reset silences every property
module lcd_regs_checker (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [3:0] pstrb, // Strobes
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire lcd_ctrl_pkg::power_mode_t power_mode, // Power mode
    input wire lcd_ctrl_pkg::lcd_cfg_t cfg, // Settings
    input wire logic [47:0] seg_func_bit, // Segment enables
    input wire logic drive_active // Drive running
);
    import lcd_ctrl_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_done;
    // A finished low-byte write; the address picks the register
    assign wr_done = psel && penable && pready && pwrite && pstrb[0];
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
    AST_IDLE_READ_ZERO: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    AST_UPPER_ZERO: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
    AST_WR_MAIN: assert property (wr_done && paddr == addr_main_ctrl |=> {cfg.waveform_b, cfg.bias_method_sel,
        cfg.cap_bias_source_sel, cfg.bias_current_sel} == {$past(pwdata[7:4]), $past(pwdata[2:1])})
        else $error("main control fields not stored");
    AST_WR_SEG_A: assert property (wr_done && paddr == addr_seg_sel_a |=> seg_func_bit[7:0] == $past(pwdata[7:0]))
        else $error("first segment select not stored");
    AST_SLEEP_OFF: assert property ($past(power_mode) == pm_sleep |-> !cfg.display_on) else $error("display on in sleep");
    AST_PUMP_ON: assert property (cfg.pump_on == (cfg.bias_method_sel || cfg.drive_supply_sel))
        else $error("pump state wrong");
    AST_DRIVE: assert property (drive_active == cfg.display_on) else $error("drive state differs");
    AST_SEG_GAP: assert property (seg_func_bit[37:16] == 22'h0) else $error("unmapped segment set");
    // Main scenarios reached
    cover property (wr_done && paddr == addr_main_ctrl);
    cover property (pslverr);
    cover property ($past(power_mode) == pm_sleep);
endmodule
`default_nettype wire

// *** sim/lcd_driver_control_regs_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module lcd_driver_control_regs_tb_top;
    import lcd_ctrl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, drive_active, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [47:0] seg_func_bit;
    power_mode_t power_mode;
    lcd_cfg_t cfg;
    int error_cnt, compares;
    // Rows: address, value written, value read back (masks drop unused bits)
    logic [27:0] rows [6] = '{{addr_pump_ctrl, 8'hFF, 8'h0B}, {addr_main_ctrl, 8'hBF, 8'hB7},
        {addr_seg_sel_a, 8'hA5, 8'hA5}, {addr_seg_sel_b, 8'h5A, 8'h5A}, {addr_seg_sel_c, 8'hFF, 8'h03},
        {addr_seg_sel_d, 8'h3C, 8'h3C}};
    lcd_driver_control_regs #(.large_variant(1'b1)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .power_mode, .cfg, .seg_func_bit, .drive_active);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One APB transfer; the request holds until ready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(negedge pclk); // Let the stored value reach the outputs
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        power_mode = pm_normal;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, rows[i][27:16], 32'h0);
            check("reset value", 32'h0, rd);
        end
        check("reset cfg", 32'h0, {21'h0, cfg});
        $display("test reset done");
        // Pump row first, while bias is still resistor type
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, rows[i][27:16], {24'h0, rows[i][15:8]});
            apb(1'b0, rows[i][27:16], 32'h0);
            check("readback", {24'h0, rows[i][7:0]}, rd);
        end
        check("cfg all", 32'h7BF, {21'h0, cfg});
        check("seg a b", 32'h5AA5, {16'h0, seg_func_bit[15:0]});
        check("seg c d", 32'h0F3, {22'h0, seg_func_bit[47:38]});
        $display("test table done");
        apb(1'b0, 12'h01C, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b0, addr_status, 32'h0);
        check("status", 32'h1, rd);
        // Supply select back to pin before capacitor bias is chosen
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, addr_pump_ctrl, 32'(v));
            check("pump volt", 32'(v), {29'h0, cfg.drive_supply_sel, cfg.pump_voltage_sel});
        end
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, addr_main_ctrl, {24'h0, v[0], v[1], v[1:0], 1'b0, v[1:0], 1'b1});
            check("main fields", {24'h0, v[0], v[1], v[1:0], v[1:0], v[1], 1'b1}, {24'h0, cfg[7:0]});
        end
        $display("test codes done");
        for (int pm = 0; pm < 4; pm++) begin
            @(posedge pclk);
            power_mode <= power_mode_t'(pm);
            repeat (2) @(negedge pclk);
            check("display on", {31'h0, pm != 3}, {31'h0, cfg.display_on});
            check("drive active", {31'h0, pm != 3}, {31'h0, drive_active});
        end
        @(posedge pclk);
        power_mode <= pm_normal;
        apb(1'b1, addr_main_ctrl, 32'h0);
        check("disabled drive", 32'h0, {30'h0, cfg.display_on, drive_active});
        $display("test power done");
        // Writes without the low byte strobe, or to the read-only status, must not store
        pstrb <= 4'hE;
        apb(1'b1, addr_seg_sel_c, 32'h00000001);
        pstrb <= 4'hF;
        apb(1'b0, addr_seg_sel_c, 32'h0);
        check("strobe off write", 32'h3, rd);
        apb(1'b1, addr_status, 32'h00000001);
        apb(1'b0, addr_status, 32'h0);
        check("status write", 32'h0, rd);
        // Reset in mid-run clears every stored field
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("mid reset seg", 32'h0, {16'h0, seg_func_bit[15:0]});
        check("mid reset cfg", 32'h0, {21'h0, cfg});
        apb(1'b0, addr_seg_sel_b, 32'h0);
        check("mid reset read", 32'h0, rd);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule
bind lcd_driver_control_regs lcd_regs_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .power_mode, .cfg, .seg_func_bit, .drive_active);
`default_nettype wire
